// ==== gcp_pkg.sv ====
// Constants and carriers for the global configuration and pin routing block.
// Assumes a serial front end that decodes frames into single register requests.
package gcp_pkg;

  // Register access
  localparam int          GCP_DATA_W       = 32;
  localparam int          GCP_ADDR_W       = 8;
  localparam int          GCP_WRITE_BIT    = 7;
  localparam logic [7:0]  GCP_WRITE_OFFSET = 8'h80;
  localparam logic [6:0]  GCP_ADDR_GCONF   = 7'h00;
  localparam logic [31:0] GCP_RDATA_ZERO   = 32'h0000_0000;

  // Global configuration layout
  localparam int          GCP_CFG_W       = 11;
  localparam logic [10:0] GCP_CFG_RESET   = 11'h000;
  localparam logic [10:0] GCP_CFG_WMASK   = 11'h7F8;
  localparam int          GCP_BIT_CMP_SEL = 3;
  localparam int          GCP_BIT_IDX1    = 4;
  localparam int          GCP_BIT_QUAD2   = 5;
  localparam int          GCP_BIT_IDX2    = 6;
  localparam int          GCP_BIT_PROBE   = 7;
  localparam int          GCP_BIT_DIR1    = 8;
  localparam int          GCP_BIT_DIR2    = 9;
  localparam int          GCP_BIT_LOCK    = 10;

  localparam int          GCP_TEST_SEL_W  = 4;
  localparam logic [3:0]  GCP_TEST_SEL_0  = 4'h0;

  typedef struct packed {
    logic                  valid;
    logic [GCP_ADDR_W-1:0] addr;
    logic [GCP_DATA_W-1:0] wdata;
  } gcp_req_s;

  typedef struct packed {
    logic a;
    logic b;
    logic n;
  } gcp_enc_s;

endpackage : gcp_pkg

// ==== gcp_index_route.sv ====
// Index channel source selector, one per encoder.
// Assumes all pin levels are already synchronous to the system clock.
`timescale 1ns/100ps
module gcp_index_route (
  input  wire logic use_switch,  // Take index from left switch
  input  wire logic ifc_sel,     // Interface select level
  input  wire logic serial_pin,  // Serial data pin level
  input  wire logic gp_pin,      // General purpose pin level
  input  wire logic switch_pin,  // Left reference switch level
  output logic      index        // Selected index level
);

  wire logic pin_source;

  // Serial pins are only free for the index when the serial link is not used
  assign pin_source = ifc_sel ? gp_pin : serial_pin;
  assign index      = use_switch ? switch_pin : pin_source;

endmodule : gcp_index_route

// ==== gcp_global_config.sv ====
// Global configuration register and shared pin routing for a dual axis controller.
// Assumes register requests arrive already decoded, one per cycle, synchronous to clk_sys.
`timescale 1ns/100ps

//
// Behaviour
// - All register state is zero after power up unless stated otherwise.
// - Write address is register address plus 0x80; device decodes it as write.
// - Read-only ignores writes, write-only reads meaningless, clear-on-read clears flags.
// - Bit 3 low maps encoder one A/B; high drives compare pulse and interrupt.
// - Bit 4 picks index one from serial or gp pin, or left switch one.
// - Bit 5 turns right switches into encoder two A and B inputs.
// - Bit 6 picks index two from inverted serial or gp pin, or left switch two.
// - Bit 7 drives analog test output on right switch two, selected by test field.
// - Bits 8 and 9 invert motor one and motor two direction.
// - After lock bit 10 is written one, further configuration writes are ignored.
module gcp_global_config
  import gcp_pkg::*;
(
  input  wire logic                      clk_sys,             // System clock, 20 MHz
  input  wire logic                      rst,                 // Async reset, active high
  input  wire gcp_req_s                  reg_req,             // Register request
  output logic [GCP_DATA_W-1:0]          reg_rdata,           // Read data
  output logic                           reg_rsp_valid,       // Answer strobe
  input  wire logic                      interface_select,    // Serial interface select
  input  wire logic                      serial_pin_true,     // True serial pin level
  input  wire logic                      serial_pin_inverted, // Inverted serial pin level
  input  wire logic                      gp_pin_zero,         // General pin 0 level
  input  wire logic                      gp_pin_one,          // General pin 1 level
  input  wire logic                      left_switch_one,     // Left switch 1 level
  input  wire logic                      left_switch_two,     // Left switch 2 level
  input  wire logic                      right_switch_one,    // Right switch 1 level
  input  wire logic                      right_switch_two,    // Right switch 2 level
  input  wire logic                      enc1_a_pin_in,       // Encoder 1 A pin level
  input  wire logic                      enc1_b_pin_in,       // Encoder 1 B pin level
  output logic                           compare_pulse_out,   // A pin drive value
  output logic                           compare_pulse_oe,    // A pin output enable
  output logic                           irq_pin_out,         // B pin drive value
  output logic                           irq_pin_oe,          // B pin output enable
  input  wire logic                      compare_event,       // Compare pulse request
  input  wire logic                      irq_event,           // Interrupt level request
  output gcp_enc_s                       enc1,                // Encoder 1 signals
  output logic                           enc1_active,         // Encoder 1 in use
  output gcp_enc_s                       enc2,                // Encoder 2 signals
  output logic                           enc2_active,         // Encoder 2 in use
  output logic                           ref_right_one,       // Right switch 1 to ramp
  output logic                           ref_right_two,       // Right switch 2 to ramp
  output logic                           ref_right_active,    // Right switches usable
  input  wire logic [GCP_TEST_SEL_W-1:0] test_select,         // Test signal select
  output logic                           probe_enable,        // Analog test drive on
  output logic [GCP_TEST_SEL_W-1:0]      probe_select,        // Analog test signal
  input  wire logic                      motor_one_dir_req,   // Motor 1 direction in
  input  wire logic                      motor_two_dir_req,   // Motor 2 direction in
  output logic                           motor_one_dir,       // Motor 1 direction out
  output logic                           motor_two_dir,       // Motor 2 direction out
  output logic [GCP_CFG_W-1:0]           global_config_q      // Configuration to core
);

  ////////////////////////////////////////////////////////////////////////////////
  // Register decode

  logic [GCP_CFG_W-1:0] global_config;
  wire logic            req_is_write;
  wire logic [6:0]      req_index;
  wire logic            hit_gconf;
  wire logic            wr_gconf;
  wire logic            rd_gconf;
  wire logic [GCP_CFG_W-1:0] next_global_config;

  assign req_is_write = reg_req.addr[GCP_WRITE_BIT];
  assign req_index    = reg_req.addr[GCP_WRITE_BIT-1:0];
  assign hit_gconf    = reg_req.valid && (req_index == GCP_ADDR_GCONF);
  // Lock is sticky: only reset frees the register again
  assign wr_gconf     = hit_gconf && req_is_write && !global_config[GCP_BIT_LOCK];
  assign rd_gconf     = hit_gconf && !req_is_write;
  // Reserved bits are never stored, so they read back as zero
  assign next_global_config = reg_req.wdata[GCP_CFG_W-1:0] & GCP_CFG_WMASK;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      global_config <= GCP_CFG_RESET;
    end else if (wr_gconf) begin
      global_config <= next_global_config;
    end
  end

  // Unmapped reads answer zero; unmapped writes fall away
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reg_rdata     <= GCP_RDATA_ZERO;
      reg_rsp_valid <= 1'b0;
    end else begin
      reg_rsp_valid <= reg_req.valid;
      reg_rdata     <= rd_gconf ? {{(GCP_DATA_W-GCP_CFG_W){1'b0}}, global_config}
                                : GCP_RDATA_ZERO;
    end
  end

  assign global_config_q = global_config;

  ////////////////////////////////////////////////////////////////////////////////
  // Pin routing

  wire logic cmp_sel;
  wire logic quad2_sel;
  wire logic probe_on;
  wire logic idx1;
  wire logic idx2;

  assign cmp_sel   = global_config[GCP_BIT_CMP_SEL];
  assign quad2_sel = global_config[GCP_BIT_QUAD2];
  assign probe_on  = global_config[GCP_BIT_PROBE];

  gcp_index_route u_idx1 (
    .use_switch (global_config[GCP_BIT_IDX1]),
    .ifc_sel    (interface_select),
    .serial_pin (serial_pin_true),
    .gp_pin     (gp_pin_zero),
    .switch_pin (left_switch_one),
    .index      (idx1)
  );

  gcp_index_route u_idx2 (
    .use_switch (global_config[GCP_BIT_IDX2]),
    .ifc_sel    (interface_select),
    .serial_pin (serial_pin_inverted),
    .gp_pin     (gp_pin_one),
    .switch_pin (left_switch_two),
    .index      (idx2)
  );

  // All routed outputs are registered, so every path carries one cycle of latency
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      enc1              <= '0;
      enc2              <= '0;
      enc1_active       <= 1'b0;
      enc2_active       <= 1'b0;
      compare_pulse_out <= 1'b0;
      compare_pulse_oe  <= 1'b0;
      irq_pin_out       <= 1'b0;
      irq_pin_oe        <= 1'b0;
    end else begin
      enc1_active       <= !cmp_sel;
      enc1.a            <= cmp_sel ? 1'b0 : enc1_a_pin_in;
      enc1.b            <= cmp_sel ? 1'b0 : enc1_b_pin_in;
      enc1.n            <= idx1;
      compare_pulse_oe  <= cmp_sel;
      irq_pin_oe        <= cmp_sel;
      compare_pulse_out <= cmp_sel && compare_event;
      irq_pin_out       <= cmp_sel && irq_event;
      enc2_active       <= quad2_sel;
      enc2.a            <= quad2_sel ? right_switch_one : 1'b0;
      enc2.b            <= quad2_sel ? right_switch_two : 1'b0;
      enc2.n            <= idx2;
    end
  end

  // Right switch two is analog while probing, so its digital level is masked
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ref_right_active <= 1'b0;
      ref_right_one    <= 1'b0;
      ref_right_two    <= 1'b0;
      probe_enable     <= 1'b0;
      probe_select     <= GCP_TEST_SEL_0;
      motor_one_dir    <= 1'b0;
      motor_two_dir    <= 1'b0;
    end else begin
      ref_right_active <= !quad2_sel;
      ref_right_one    <= !quad2_sel && right_switch_one;
      ref_right_two    <= !quad2_sel && !probe_on && right_switch_two;
      probe_enable     <= probe_on;
      probe_select     <= probe_on ? test_select : GCP_TEST_SEL_0;
      motor_one_dir    <= motor_one_dir_req ^ global_config[GCP_BIT_DIR1];
      motor_two_dir    <= motor_two_dir_req ^ global_config[GCP_BIT_DIR2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_cfg_write;
    reg_req.valid && reg_req.addr == (GCP_WRITE_OFFSET | {1'b0, GCP_ADDR_GCONF});
  endsequence

  a_reset_zero: assert property ($past(rst) |-> global_config == GCP_CFG_RESET)
    else $error("config not zero after reset");

  a_write_takes: assert property (s_cfg_write ##0 !global_config[GCP_BIT_LOCK]
    |=> global_config == ($past(reg_req.wdata[GCP_CFG_W-1:0]) & GCP_CFG_WMASK))
    else $error("write to config not taken");

  a_read_no_write: assert property (reg_req.valid && !reg_req.addr[GCP_WRITE_BIT]
    |=> $stable(global_config))
    else $error("read changed config");

  a_lock_holds: assert property (global_config[GCP_BIT_LOCK] |=> $stable(global_config))
    else $error("locked config changed");

  a_read_answer: assert property (reg_req.valid
    && reg_req.addr[GCP_WRITE_BIT-1:0] == GCP_ADDR_GCONF
    |=> reg_rsp_valid && reg_rdata[GCP_BIT_CMP_SEL-1:0] == '0)
    else $error("bad config read answer");

  a_cmp_drive: assert property (cmp_sel && $stable(cmp_sel) |=> compare_pulse_oe && irq_pin_oe
    && compare_pulse_out == $past(compare_event) && !enc1_active)
    else $error("compare pins not driven");

  a_enc1_free: assert property (!cmp_sel |=> !compare_pulse_oe && enc1.a == $past(enc1_a_pin_in))
    else $error("encoder one pins not mapped");

  a_idx1_route: assert property (global_config[GCP_BIT_IDX1] |=> enc1.n == $past(left_switch_one))
    else $error("index one source wrong");

  a_idx2_route: assert property (!global_config[GCP_BIT_IDX2] && interface_select
    |=> enc2.n == $past(gp_pin_one))
    else $error("index two source wrong");

  a_quad2_map: assert property (quad2_sel |=> enc2.b == $past(right_switch_two) && !ref_right_active)
    else $error("encoder two not on right switches");

  a_probe_map: assert property (probe_on |=> probe_enable && !ref_right_two
    && probe_select == $past(test_select))
    else $error("analog probe not routed");

  a_dir_invert: assert property (1'b1 |=> motor_two_dir
    == ($past(motor_two_dir_req) ^ $past(global_config[GCP_BIT_DIR2])))
    else $error("motor two direction wrong");

endmodule : gcp_global_config

// ==== gcp_host_model.sv ====
// Host side model: issues single register requests and collects each answer.
// Assumes the device answers exactly one clock after the request edge.
`timescale 1ns/100ps
module gcp_host_model
  import gcp_pkg::*;
(
  input  wire logic                  clk_sys,      // System clock
  output gcp_req_s                   reg_req,      // Request to device
  input  wire logic [GCP_DATA_W-1:0] reg_rdata,    // Read data
  input  wire logic                  reg_rsp_valid // Answer strobe
);
  initial reg_req = '0;

  // Idle bus shows the inverse, so a stale request never looks live
  task automatic issue(input logic [7:0] addr, input logic [31:0] wdata,
                       output logic [31:0] rdata, output logic got);
    @(posedge clk_sys);
    #1;
    reg_req = '{valid: 1'b1, addr: addr, wdata: wdata};
    @(posedge clk_sys);
    #1;
    reg_req = '{valid: 1'b0, addr: ~addr, wdata: ~wdata};
    got = reg_rsp_valid;
    rdata = reg_rdata;
  endtask : issue

  task automatic write_reg(input logic [6:0] ra, input logic [31:0] wdata,
                           output logic [31:0] rdata, output logic got);
    issue({1'b0, ra} + GCP_WRITE_OFFSET, wdata & ~32'h7, rdata, got);
  endtask : write_reg

  task automatic read_reg(input logic [6:0] ra, output logic [31:0] rdata, output logic got);
    issue({1'b0, ra}, 32'h0, rdata, got);
  endtask : read_reg
endmodule : gcp_host_model

// ==== tb.sv ====
// Self-checking bench for the global configuration and pin routing block.
// Assumes the host model drives the register port; pins are driven here.
`timescale 1ns/100ps
module tb;
  import gcp_pkg::*;
  logic clk_sys, rst, reg_rsp_valid, got;
  gcp_req_s reg_req;
  logic [31:0] reg_rdata, rd, seed;
  logic interface_select, serial_pin_true, serial_pin_inverted, gp_pin_zero, gp_pin_one;
  logic left_switch_one, left_switch_two, right_switch_one, right_switch_two;
  logic enc1_a_pin_in, enc1_b_pin_in, compare_event, irq_event;
  logic motor_one_dir_req, motor_two_dir_req, compare_pulse_out, compare_pulse_oe;
  logic irq_pin_out, irq_pin_oe, enc1_active, enc2_active, probe_enable;
  logic ref_right_one, ref_right_two, ref_right_active, motor_one_dir, motor_two_dir;
  logic [3:0] test_select, probe_select;
  logic [10:0] global_config_q;
  gcp_enc_s enc1, enc2;
  int n_errors = 0;
  int checks_done = 0;
  int model_cfg;
  bit model_lock;

  gcp_global_config dut (
    .clk_sys             (clk_sys),
    .rst                 (rst),
    .reg_req             (reg_req),
    .reg_rdata           (reg_rdata),
    .reg_rsp_valid       (reg_rsp_valid),
    .interface_select    (interface_select),
    .serial_pin_true     (serial_pin_true),
    .serial_pin_inverted (serial_pin_inverted),
    .gp_pin_zero         (gp_pin_zero),
    .gp_pin_one          (gp_pin_one),
    .left_switch_one     (left_switch_one),
    .left_switch_two     (left_switch_two),
    .right_switch_one    (right_switch_one),
    .right_switch_two    (right_switch_two),
    .enc1_a_pin_in       (enc1_a_pin_in),
    .enc1_b_pin_in       (enc1_b_pin_in),
    .compare_pulse_out   (compare_pulse_out),
    .compare_pulse_oe    (compare_pulse_oe),
    .irq_pin_out         (irq_pin_out),
    .irq_pin_oe          (irq_pin_oe),
    .compare_event       (compare_event),
    .irq_event           (irq_event),
    .enc1                (enc1),
    .enc1_active         (enc1_active),
    .enc2                (enc2),
    .enc2_active         (enc2_active),
    .ref_right_one       (ref_right_one),
    .ref_right_two       (ref_right_two),
    .ref_right_active    (ref_right_active),
    .test_select         (test_select),
    .probe_enable        (probe_enable),
    .probe_select        (probe_select),
    .motor_one_dir_req   (motor_one_dir_req),
    .motor_two_dir_req   (motor_two_dir_req),
    .motor_one_dir       (motor_one_dir),
    .motor_two_dir       (motor_two_dir),
    .global_config_q     (global_config_q)
  );
  gcp_host_model host (
    .clk_sys       (clk_sys),
    .reg_req       (reg_req),
    .reg_rdata     (reg_rdata),
    .reg_rsp_valid (reg_rsp_valid)
  );

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish

  ////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [6:0] ra, input logic [31:0] d);
    host.write_reg(ra, d, rd, got);
    chk({got, rd}, {1'b1, 32'h0});
    if (ra == GCP_ADDR_GCONF && !model_lock) model_cfg = d & GCP_CFG_WMASK;
    model_lock = model_cfg[GCP_BIT_LOCK];
  endtask : wr

  task automatic rd_cfg(input logic [6:0] ra);
    host.read_reg(ra, rd, got);
    chk({got, rd}, {1'b1, (ra == 7'h00) ? model_cfg : 32'h0});
    chk(global_config_q, model_cfg);
  endtask : rd_cfg

  task automatic check_pins(input logic [10:0] c);
    logic n1, n2;
    n1 = c[4] ? left_switch_one : (interface_select ? gp_pin_zero : serial_pin_true);
    n2 = c[6] ? left_switch_two : (interface_select ? gp_pin_one : serial_pin_inverted);
    chk({compare_pulse_oe, irq_pin_oe, enc1_active}, {c[3], c[3], !c[3]});
    chk({enc1.a, enc1.b}, c[3] ? 2'b00 : {enc1_a_pin_in, enc1_b_pin_in});
    if (c[3]) chk({compare_pulse_out, irq_pin_out}, {compare_event, irq_event});
    else chk(enc1.n, n1);
    chk({enc2_active, enc2.a, enc2.b}, c[5] ? {1'b1, right_switch_one, right_switch_two} : 3'h0);
    chk({ref_right_active, ref_right_one}, c[5] ? 2'b00 : {1'b1, right_switch_one});
    chk(ref_right_two, (c[5] | c[7]) ? 1'b0 : right_switch_two);
    if (c[5]) chk(enc2.n, n2);
    chk({probe_enable, probe_select}, c[7] ? {1'b1, test_select} : 5'h00);
    chk({motor_one_dir, motor_two_dir},
        {motor_one_dir_req ^ c[8], motor_two_dir_req ^ c[9]});
  endtask : check_pins

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    seed = 32'hC572;
    test_select = 4'h0;
    {interface_select, serial_pin_true, serial_pin_inverted, gp_pin_zero, gp_pin_one,
     left_switch_one, left_switch_two, right_switch_one, right_switch_two, enc1_a_pin_in,
     enc1_b_pin_in, compare_event, irq_event, motor_one_dir_req, motor_two_dir_req} = '0;
    model_cfg = 0;
    model_lock = 0;
    repeat (10) @(posedge clk_sys);
    #1 rst = 1'b0;
    rd_cfg(7'h00);
    $display("test reset done");
    for (int i = 0; i < 40; i++) begin
      seed = lfsr(seed);
      wr(7'h00, seed & 32'h3FF);
      rd_cfg(7'h00);
      seed = lfsr(seed);
      test_select = model_cfg[7] ? seed[19:16] : 4'h0;
      {interface_select, serial_pin_true, serial_pin_inverted, gp_pin_zero, gp_pin_one,
       left_switch_one, left_switch_two, right_switch_one, right_switch_two, enc1_a_pin_in,
       enc1_b_pin_in, compare_event, irq_event, motor_one_dir_req, motor_two_dir_req}
        = seed[14:0];
      repeat (2) @(posedge clk_sys);
      #1 check_pins(model_cfg[10:0]);
    end
    $display("test routing done");
    wr(7'h05, 32'h0000_07F8);
    rd_cfg(7'h05);
    $display("test unmapped done");
    wr(7'h00, 32'h0000_0450);
    wr(7'h00, 32'h0000_0228);
    rd_cfg(7'h00);
    #1 rst = 1'b1;
    repeat (2) @(posedge clk_sys);
    #1 rst = 1'b0;
    model_cfg = 0;
    model_lock = 0;
    rd_cfg(7'h00);
    wr(7'h00, 32'h0000_0028);
    rd_cfg(7'h00);
    $display("test lock done");
    tally_and_finish();
  end

  initial begin
    #(50 * 5000);
    n_errors++;
    tally_and_finish();
  end
endmodule : tb
